// File: ebsc_ctrl.sv
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module ebsc_ctrl
    import ebsc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    output logic test_clock_low_phase,
    output logic chain_cell_mux_select,
    output logic extest_capture_pulse,
    output logic intest_capture_pulse,
    output logic chain_update_pulse,
    output logic chain_reset_flag,
    output logic [3:0] opcode_latch_view,
    output logic [4:0] selected_chain_number,
    output logic chain_serial_out,
    input wire logic chain_serial_return
);
    // tap next-state function
    function automatic ebsc_tap_e tap_next(input ebsc_tap_e s,
                                           input logic m);
        case (s)
            TS_RESET: tap_next = m ? TS_RESET : TS_IDLE;
            TS_IDLE: tap_next = m ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: tap_next = m ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: tap_next = m ? TS_EXIT1_DR : TS_SHIFT_DR;
            TS_SHIFT_DR: tap_next = m ? TS_EXIT1_DR : TS_SHIFT_DR;
            TS_EXIT1_DR: tap_next = m ? TS_UPD_DR : TS_PAUSE_DR;
            TS_PAUSE_DR: tap_next = m ? TS_EXIT2_DR : TS_PAUSE_DR;
            TS_EXIT2_DR: tap_next = m ? TS_UPD_DR : TS_SHIFT_DR;
            TS_UPD_DR: tap_next = m ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: tap_next = m ? TS_RESET : TS_CAP_IR;
            TS_CAP_IR: tap_next = m ? TS_EXIT1_IR : TS_SHIFT_IR;
            TS_SHIFT_IR: tap_next = m ? TS_EXIT1_IR : TS_SHIFT_IR;
            TS_EXIT1_IR: tap_next = m ? TS_UPD_IR : TS_PAUSE_IR;
            TS_PAUSE_IR: tap_next = m ? TS_EXIT2_IR : TS_PAUSE_IR;
            TS_EXIT2_IR: tap_next = m ? TS_UPD_IR : TS_SHIFT_IR;
            TS_UPD_IR: tap_next = m ? TS_SEL_DR : TS_IDLE;
            default: tap_next = TS_RESET;
        endcase
    endfunction : tap_next

    // true for the ops that put the external cells in charge
    function automatic logic is_bs_op(input logic [3:0] op);
        is_bs_op = (op == EBSC_OP_INTEST) || (op == EBSC_OP_EXTEST) ||
                   (op == EBSC_OP_CLAMP) || (op == EBSC_OP_CLAMPZ);
    endfunction : is_bs_op

    // test clock domain state
    typedef struct packed {
        ebsc_tap_e st;
        logic [3:0] ir_sr;
        logic [4:0] sc_sr;
        logic byp;
        logic sout;
        logic tdo;
        logic tdo_oe_n;
        logic pres_s1;
        logic pres_s2;
        logic [EBSC_SNAP_W-1:0] snap;
        logic req;
        logic ack_s1;
        logic ack_s2;
        logic ch3;
    } ebsc_tck_s;

    // bus clock domain state
    typedef struct packed {
        logic present;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic [31:0] rdata;
        logic [EBSC_SNAP_W-1:0] stat;
        logic req_s1;
        logic req_s2;
        logic seen;
    } ebsc_bus_s;

    ebsc_tck_s t_q;
    ebsc_tck_s t_d;
    ebsc_bus_s b_q;
    ebsc_bus_s b_d;

    logic [4:0] opmux;
    logic op_load;
    logic [4:0] opmux_new;
    logic chain_load;
    logic chain3;
    logic [EBSC_SNAP_W-1:0] live;
    logic ap_take;

    // qualifying terms shared by the pulses and the falling-edge loads
    assign chain3 = (selected_chain_number == EBSC_EXT_CHAIN);
    assign op_load = (t_q.st == TS_UPD_IR) || (t_q.st == TS_RESET);
    assign opmux_new = (t_q.st == TS_RESET) ? {1'b0, EBSC_OP_IDCODE} :
                       {chain3 && is_bs_op(t_q.ir_sr), t_q.ir_sr};
    assign chain_load = ((t_q.st == TS_UPD_DR) &&
                         (opcode_latch_view == EBSC_OP_SCAN_N)) ||
                        (t_q.st == TS_RESET);

    // opcode view and mux select, loaded on the falling edge
    ebsc_fall_reg #(
        .WIDTH(5),
        .RST_VAL({1'b0, EBSC_OP_IDCODE})
    ) u_opc (
        .tck(tck),
        .trst_n(trst_n),
        .load(op_load),
        .din(opmux_new),
        .dout(opmux)
    );

    // chain number, loaded on the falling edge
    ebsc_fall_reg #(
        .WIDTH(5),
        .RST_VAL(EBSC_CHAIN_RST)
    ) u_chn (
        .tck(tck),
        .trst_n(trst_n),
        .load(chain_load),
        .din((t_q.st == TS_RESET) ? EBSC_CHAIN_RST : t_q.sc_sr),
        .dout(selected_chain_number)
    );

    assign opcode_latch_view = opmux[3:0];
    assign chain_cell_mux_select = opmux[4];
    assign live = {opmux[4], selected_chain_number, opmux[3:0]};

    // tap, shift paths and status handshake on the rising test clock
    always_comb begin
        t_d = t_q;
        t_d.st = tap_next(t_q.st, tms);
        t_d.pres_s1 = b_q.present;
        t_d.pres_s2 = t_q.pres_s1;
        t_d.ack_s1 = b_q.seen;
        t_d.ack_s2 = t_q.ack_s1;
        t_d.ch3 = chain3; // chain selection held over the next low phase
        case (t_q.st)
            TS_CAP_IR: t_d.ir_sr = EBSC_IR_CAPTURE;
            TS_SHIFT_IR: t_d.ir_sr = {tdi, t_q.ir_sr[3:1]};
            TS_CAP_DR: begin
                t_d.sc_sr = selected_chain_number;
                t_d.byp = 1'b0;
            end
            TS_SHIFT_DR: begin
                t_d.sc_sr = {tdi, t_q.sc_sr[4:1]};
                t_d.byp = tdi;
            end
            default: begin
            end
        endcase
        // serial data changes on the rising edge, so it sits still
        // around the following falling edge
        if (t_q.st == TS_SHIFT_DR) begin
            t_d.sout = tdi;
        end
        // test data out and its enable
        t_d.tdo_oe_n = !((t_q.st == TS_SHIFT_DR) ||
                         (t_q.st == TS_SHIFT_IR));
        if (t_q.st == TS_SHIFT_IR) begin
            t_d.tdo = t_q.ir_sr[0];
        end else if (opcode_latch_view == EBSC_OP_SCAN_N) begin
            t_d.tdo = t_q.sc_sr[0];
        end else if (chain3 && is_bs_op(opcode_latch_view)) begin
            // return sampled at the rising edge; absent chain reads low
            t_d.tdo = chain_serial_return && t_q.pres_s2;
        end else begin
            t_d.tdo = t_q.byp;
        end
        // post a fresh snapshot once the last one was taken
        if ((t_q.req == t_q.ack_s2) && (t_q.snap != live)) begin
            t_d.snap = live;
            t_d.req = !t_q.req;
        end
    end

    // test clock registers, set to their reset values by the test reset
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            t_q <= '{st: TS_RESET, ir_sr: EBSC_IR_CAPTURE,
                     sc_sr: EBSC_CHAIN_RST, snap: {1'b0, EBSC_CHAIN_RST,
                     EBSC_OP_IDCODE}, tdo_oe_n: 1'b1, default: 1'b0};
        end else begin
            t_q <= t_d;
        end
    end

    // pulses are gated by the low phase of the test clock; the chain term
    // comes from the rising edge so a chain load cannot glitch a pulse
    assign test_clock_low_phase = !tck;
    assign extest_capture_pulse = test_clock_low_phase &&
        (t_q.st == TS_CAP_DR) && t_q.ch3 &&
        (opcode_latch_view == EBSC_OP_EXTEST);
    assign intest_capture_pulse = test_clock_low_phase &&
        (t_q.st == TS_CAP_DR) && t_q.ch3 &&
        (opcode_latch_view == EBSC_OP_INTEST);
    assign chain_update_pulse = test_clock_low_phase &&
        (t_q.st == TS_UPD_DR) && t_q.ch3;
    assign chain_reset_flag = (t_q.st == TS_RESET) || !trst_n;
    assign chain_serial_out = t_q.sout;
    assign tdo = t_q.tdo;
    assign tdo_oe_n = t_q.tdo_oe_n;

    // bus slave: zero wait states, stalls only while frozen
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = b_q.rdata;
    assign ap_take = hsel && htrans[1] && hready;

    always_comb begin
        b_d = b_q;
        b_d.req_s1 = t_q.req;
        b_d.req_s2 = b_q.req_s1;
        // take the snapshot, it is held while the toggles differ
        if (b_q.req_s2 != b_q.seen) begin
            b_d.stat = t_q.snap;
            b_d.seen = b_q.req_s2;
        end
        // data phase of a write
        if (b_q.ap_valid && b_q.ap_write &&
            (b_q.ap_addr == EBSC_CTRL_OFS)) begin
            b_d.present = hwdata[EBSC_CTRL_PRESENT_BIT];
        end
        // address phase: latch it and prepare read data
        b_d.ap_valid = ap_take;
        b_d.ap_write = hwrite;
        b_d.ap_addr = haddr[7:0];
        b_d.rdata = 32'h0000_0000;
        if (ap_take && !hwrite && (haddr[31:8] == 24'h00_0000)) begin
            if (haddr[7:0] == EBSC_CTRL_OFS) begin
                b_d.rdata[EBSC_CTRL_PRESENT_BIT] = b_q.present;
            end else if (haddr[7:0] == EBSC_STAT_OFS) begin
                b_d.rdata[EBSC_STAT_MUX_BIT:EBSC_STAT_OPC_LSB] = b_q.stat;
            end
        end
        if (haddr[31:8] != 24'h00_0000) begin
            b_d.ap_addr = 8'hff;
        end
    end

    // bus clock registers, frozen while the clock enable is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            b_q <= '{present: EBSC_CTRL_RST[EBSC_CTRL_PRESENT_BIT],
                     rdata: 32'h0000_0000,
                     stat: {1'b0, EBSC_CHAIN_RST, EBSC_OP_IDCODE},
                     default: '0};
        end else if (ce) begin
            b_q <= b_d;
        end
    end

    // qualifying sequences for the pulse checks
    sequence s_cap_ext;
        (t_q.st == TS_CAP_DR) && chain3 &&
            (opcode_latch_view == EBSC_OP_EXTEST);
    endsequence
    sequence s_cap_int;
        (t_q.st == TS_CAP_DR) && chain3 &&
            (opcode_latch_view == EBSC_OP_INTEST);
    endsequence

    // sampled at the rising edge the low phase has just run
    property p_ext_cap;
        @(posedge tck) disable iff (!trst_n)
        s_cap_ext |-> extest_capture_pulse;
    endproperty
    a_ext_cap: assert property (p_ext_cap)
        else $error("extest capture pulse missing");

    property p_int_cap;
        @(posedge tck) disable iff (!trst_n)
        s_cap_int |-> intest_capture_pulse && !extest_capture_pulse;
    endproperty
    a_int_cap: assert property (p_int_cap)
        else $error("intest capture pulse missing");

    property p_upd;
        @(posedge tck) disable iff (!trst_n)
        (t_q.st == TS_UPD_DR) && $past(chain3) |-> chain_update_pulse;
    endproperty
    a_upd: assert property (p_upd)
        else $error("update pulse missing");

    property p_quiet;
        @(posedge tck) disable iff (!trst_n)
        !((t_q.st == TS_CAP_DR) || (t_q.st == TS_UPD_DR)) |->
            !extest_capture_pulse && !intest_capture_pulse &&
            !chain_update_pulse;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("pulse outside its state");

    property p_rst_flag;
        @(posedge tck) disable iff (!trst_n)
        tms [*5] |=> chain_reset_flag;
    endproperty
    a_rst_flag: assert property (p_rst_flag)
        else $error("chain reset flag low in reset state");

    property p_opc_when;
        @(posedge tck) disable iff (!trst_n)
        $changed(opcode_latch_view) |->
            (t_q.st == TS_UPD_IR) || (t_q.st == TS_RESET);
    endproperty
    a_opc_when: assert property (p_opc_when)
        else $error("opcode view changed outside update-ir");

    property p_opc_what;
        @(posedge tck) disable iff (!trst_n)
        (t_q.st == TS_UPD_IR) |-> opcode_latch_view == t_q.ir_sr;
    endproperty
    a_opc_what: assert property (p_opc_what)
        else $error("opcode view not loaded in update-ir");

    property p_chn_when;
        @(posedge tck) disable iff (!trst_n)
        $changed(selected_chain_number) |->
            (t_q.st == TS_UPD_DR) || (t_q.st == TS_RESET);
    endproperty
    a_chn_when: assert property (p_chn_when)
        else $error("chain number changed outside update-dr");

    property p_mux;
        @(posedge tck) disable iff (!trst_n)
        $changed(chain_cell_mux_select) |->
            (t_q.st == TS_UPD_IR) || (t_q.st == TS_RESET);
    endproperty
    a_mux: assert property (p_mux)
        else $error("mux select changed outside update-ir");

    property p_sout;
        @(posedge tck) disable iff (!trst_n)
        (t_q.st == TS_SHIFT_DR) ##1 1'b1 |-> chain_serial_out == $past(tdi);
    endproperty
    a_sout: assert property (p_sout)
        else $error("serial out does not follow shifted data");

    property p_ready;
        @(posedge hclk) disable iff (!hresetn)
        ce |-> hreadyout && !hresp;
    endproperty
    a_ready: assert property (p_ready)
        else $error("slave stalled while enabled");
endmodule : ebsc_ctrl

// File: ebsc_fall_reg.sv
`timescale 1ns/1ps

// shared constants for the external chain controller
package ebsc_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] EBSC_CTRL_OFS = 8'h00;
    localparam logic [7:0] EBSC_STAT_OFS = 8'h04;
    // control register fields
    localparam int EBSC_CTRL_PRESENT_BIT = 0;
    localparam logic [31:0] EBSC_CTRL_RST = 32'h0000_0000;
    // status register fields
    localparam int EBSC_STAT_OPC_LSB = 0;
    localparam int EBSC_STAT_CHN_LSB = 4;
    localparam int EBSC_STAT_MUX_BIT = 9;
    localparam int EBSC_SNAP_W = 10;
    // instruction codes, plain defaults
    localparam logic [3:0] EBSC_OP_EXTEST = 4'h0;
    localparam logic [3:0] EBSC_OP_SCAN_N = 4'h2;
    localparam logic [3:0] EBSC_OP_CLAMP = 4'h5;
    localparam logic [3:0] EBSC_OP_CLAMPZ = 4'h9;
    localparam logic [3:0] EBSC_OP_INTEST = 4'hc;
    localparam logic [3:0] EBSC_OP_IDCODE = 4'he;
    localparam logic [3:0] EBSC_OP_BYPASS = 4'hf;
    // the external chain number and reset values
    localparam logic [4:0] EBSC_EXT_CHAIN = 5'h03;
    localparam logic [4:0] EBSC_CHAIN_RST = 5'h00;
    localparam logic [3:0] EBSC_IR_CAPTURE = 4'h1;
    // tap controller states, one-hot
    typedef enum logic [15:0] {
        TS_RESET = 16'h0001, TS_IDLE = 16'h0002, TS_SEL_DR = 16'h0004,
        TS_CAP_DR = 16'h0008, TS_SHIFT_DR = 16'h0010,
        TS_EXIT1_DR = 16'h0020, TS_PAUSE_DR = 16'h0040,
        TS_EXIT2_DR = 16'h0080, TS_UPD_DR = 16'h0100,
        TS_SEL_IR = 16'h0200, TS_CAP_IR = 16'h0400,
        TS_SHIFT_IR = 16'h0800, TS_EXIT1_IR = 16'h1000,
        TS_PAUSE_IR = 16'h2000, TS_EXIT2_IR = 16'h4000,
        TS_UPD_IR = 16'h8000
    } ebsc_tap_e;
endpackage : ebsc_pkg

// register loaded on the falling test clock edge
module ebsc_fall_reg
    import ebsc_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic tck,
    input wire logic trst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] val;
    } ebsc_fr_s;

    ebsc_fr_s r_q;
    ebsc_fr_s r_d;

    // next value: load or hold
    always_comb begin
        r_d = r_q;
        if (load) begin
            r_d.val = din;
        end
    end

    // state changes only on the falling edge
    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            r_q <= '{val: RST_VAL};
        end else begin
            r_q <= r_d;
        end
    end

    assign dout = r_q.val;
endmodule : ebsc_fall_reg

// File: ebsc_chain_model.sv
`timescale 1ns/1ps

// behavioural chain of external boundary cells on the controller pins
module ebsc_chain_model #(
    parameter int CELLS = 8,
    parameter bit PRESENT = 1'b1
) (
    input wire logic tck,
    input wire logic chain_serial_out,
    input wire logic capture_pulse,
    input wire logic chain_update_pulse,
    input wire logic chain_reset_flag,
    output logic chain_serial_return
);
    logic [CELLS-1:0] shift_q;
    logic [CELLS-1:0] hold_q;

    // cells load a pin pattern on capture, else shift after falling tck
    always @(negedge tck or posedge capture_pulse or posedge chain_reset_flag)
    begin
        if (chain_reset_flag) begin
            shift_q <= '0;
        end else if (capture_pulse) begin
            shift_q <= CELLS'(8'h5a);
        end else begin
            shift_q <= {chain_serial_out, shift_q[CELLS-1:1]};
        end
    end

    // update stage latches the shifted pattern
    always @(posedge chain_update_pulse or posedge chain_reset_flag) begin
        hold_q <= chain_reset_flag ? '0 : shift_q;
    end

    // return moves after falling tck or when the chain reset flag rises, low when no chain is fitted
    assign chain_serial_return = PRESENT ? shift_q[0] : 1'b0;
endmodule : ebsc_chain_model

// File: ebsc_ctrl_tb.sv
`timescale 1ns/1ps

// bench for the external chain controller
module ebsc_ctrl_tb;
    import ebsc_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp, tdo, tdo_oe_n, tclp, mux, ecap, icap, upd, rstf;
    logic [31:0] hrdata;
    logic tck = 1'b0;
    logic trst_n = 1'b0;
    logic tms = 1'b1;
    logic tdi = 1'b0;
    logic [3:0] opc;
    logic [4:0] chn;
    logic sout, sret;
    logic rd_ph = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'ha856_3704;
    logic [3:0] cur_opc = EBSC_OP_IDCODE;
    logic [4:0] cur_chn = EBSC_CHAIN_RST;
    logic [3:0] ops[5] = '{EBSC_OP_EXTEST, EBSC_OP_INTEST, EBSC_OP_CLAMP,
                          EBSC_OP_CLAMPZ, EBSC_OP_BYPASS};
    logic mux_e;
    int errors = 0, comparisons = 0, n_ecap = 0, n_icap = 0, n_upd = 0;

    // bus clock, and a test clock of unrelated phase
    always #2.5 hclk = ~hclk;
    always #6 tck = ~tck;

    ebsc_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .tck(tck), .trst_n(trst_n),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
        .test_clock_low_phase(tclp), .chain_cell_mux_select(mux),
        .extest_capture_pulse(ecap), .intest_capture_pulse(icap),
        .chain_update_pulse(upd), .chain_reset_flag(rstf),
        .opcode_latch_view(opc), .selected_chain_number(chn),
        .chain_serial_out(sout), .chain_serial_return(sret));

    ebsc_chain_model #(.CELLS(8), .PRESENT(1'b1)) chain (.tck(tck),
        .chain_serial_out(sout), .capture_pulse(ecap | icap),
        .chain_update_pulse(upd), .chain_reset_flag(rstf),
        .chain_serial_return(sret));

    // pulse counters; totals show missing or stray pulses
    always @(posedge ecap) n_ecap++;
    always @(posedge icap) n_icap++;
    always @(posedge upd) n_upd++;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    task automatic cmp(input string what, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : cmp

    task automatic complete_run;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    // read data taken at the edge closing each read data phase
    always @(posedge hclk) begin
        if (rd_ph && hreadyout === 1'b1 && exp_q.size() > 0) begin
            cmp("hrdata", exp_q.pop_front(), hrdata);
            cmp("hresp", 32'h0000_0000, 32'(hresp));
        end
    end

    // one single word transfer; reads note their expected data
    task automatic ahb(input logic wr, input logic [31:0] a, d, e);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_ph <= !wr;
        if (!wr) exp_q.push_back(e);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_ph <= 1'b0;
    endtask : ahb

    task automatic step(input logic m, input logic d);
        @(negedge tck);
        tms <= m;
        tdi <= d;
        @(posedge tck);
    endtask : step

    // one scan from idle back to idle, views checked around update
    task automatic scan(input logic ir, input logic [7:0] v, input int nb,
                        input logic [3:0] eo, input logic [4:0] ec,
                        input logic so);
        step(1'b1, 1'b0);
        if (ir) step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        for (int i = 0; i < nb; i++) begin
            step(i == nb - 1, v[i]);
            #5;
            if (so) cmp("serial_out", 32'(v[i]), 32'(sout));
            cmp("tdo_oe_n", 32'h0000_0000, 32'(tdo_oe_n));
            if (ir) begin
                cmp("tdo_ir", 32'(i == 0), 32'(tdo));
            end else if (cur_opc == EBSC_OP_SCAN_N) begin
                cmp("tdo_chain", 32'(cur_chn[i]), 32'(tdo));
            end
        end
        step(1'b1, 1'b0);
        #5;
        cmp("opcode_early", 32'(cur_opc), 32'(opc));
        cmp("tdo_oe_n", 32'h0000_0001, 32'(tdo_oe_n));
        cmp("chain_early", 32'(cur_chn), 32'(chn));
        @(negedge tck);
        tms <= 1'b0;
        #1;
        cmp("low_phase", 32'h0000_0001, 32'(tclp));
        cmp("opcode", 32'(eo), 32'(opc));
        cmp("chain", 32'(ec), 32'(chn));
        cur_opc = eo;
        cur_chn = ec;
        @(posedge tck);
    endtask : scan

    // main sequence
    initial begin
        repeat (5) @(posedge hclk);
        cmp("reset_flag", 32'h0000_0001, 32'(rstf));
        hresetn <= 1'b1;
        trst_n <= 1'b1;
        step(1'b1, 1'b0);
        #1;
        cmp("reset_flag", 32'h0000_0001, 32'(rstf));
        step(1'b0, 1'b0);
        #1;
        cmp("reset_flag", 32'h0000_0000, 32'(rstf));
        // bus: control bit, unmapped place, stall by clock enable
        seed = xs(seed);
        ahb(1'b1, 32'(EBSC_CTRL_OFS), 32'h0000_0001, 32'h0000_0000);
        ahb(1'b0, 32'(EBSC_CTRL_OFS), 32'h0000_0000, 32'h0000_0001);
        ahb(1'b1, 32'h0000_0008, seed, 32'h0000_0000);
        ahb(1'b0, 32'h0000_0008, 32'h0000_0000, 32'h0000_0000);
        @(posedge hclk);
        ce <= 1'b0;
        @(posedge hclk);
        cmp("hreadyout", 32'h0000_0000, 32'(hreadyout));
        ce <= 1'b1;
        $display("test bus done");
        // select the external chain, then extest, intest, clamp, clampz and bypass on it
        scan(1'b1, 8'(EBSC_OP_SCAN_N), 4, EBSC_OP_SCAN_N, cur_chn, 1'b0);
        scan(1'b0, 8'h03, 5, cur_opc, EBSC_EXT_CHAIN, 1'b0);
        foreach (ops[k]) begin
            mux_e = (ops[k] != EBSC_OP_BYPASS);
            scan(1'b1, 8'(ops[k]), 4, ops[k], cur_chn, 1'b0);
            cmp("mux_select", 32'(mux_e), 32'(mux));
            n_ecap = 0;
            n_icap = 0;
            n_upd = 0;
            seed = xs(seed);
            scan(1'b0, seed[7:0], 8, cur_opc, cur_chn,
                 ops[k] == EBSC_OP_EXTEST || ops[k] == EBSC_OP_INTEST);
            cmp("ecap", 32'(ops[k] == EBSC_OP_EXTEST), 32'(n_ecap));
            cmp("icap", 32'(ops[k] == EBSC_OP_INTEST), 32'(n_icap));
            cmp("update", 32'h0000_0001, 32'(n_upd));
            repeat (8) step(1'b0, 1'b0);
            ahb(1'b0, 32'(EBSC_STAT_OFS), 32'h0000_0000,
                {22'h0, mux_e, cur_chn, cur_opc});
        end
        $display("test chain three done");
        // another chain: no pulses at all
        scan(1'b1, 8'(EBSC_OP_SCAN_N), 4, EBSC_OP_SCAN_N, cur_chn, 1'b0);
        scan(1'b0, 8'h01, 5, cur_opc, 5'h01, 1'b0);
        scan(1'b1, 8'(EBSC_OP_EXTEST), 4, EBSC_OP_EXTEST, cur_chn, 1'b0);
        n_ecap = 0;
        n_icap = 0;
        n_upd = 0;
        scan(1'b0, 8'h3c, 8, cur_opc, cur_chn, 1'b0);
        cmp("pulses", 32'h0000_0000, 32'(n_ecap + n_icap + n_upd));
        $display("test other chain done");
        // tap reset state by five ones, then reset pin in mid-run
        repeat (5) step(1'b1, 1'b0);
        @(negedge tck);
        #1;
        cmp("reset_flag", 32'h0000_0001, 32'(rstf));
        cmp("opcode", 32'(EBSC_OP_IDCODE), 32'(opc));
        cmp("chain", 32'(EBSC_CHAIN_RST), 32'(chn));
        cur_opc = EBSC_OP_IDCODE;
        cur_chn = EBSC_CHAIN_RST;
        step(1'b0, 1'b0);
        scan(1'b1, 8'(EBSC_OP_EXTEST), 4, EBSC_OP_EXTEST, cur_chn, 1'b0);
        // test reset pin held low across test clock edges
        @(posedge hclk);
        trst_n <= 1'b0;
        repeat (2) @(posedge tck);
        #1;
        cmp("reset_flag", 32'h0000_0001, 32'(rstf));
        cmp("opcode", 32'(EBSC_OP_IDCODE), 32'(opc));
        @(posedge hclk);
        trst_n <= 1'b1;
        step(1'b1, 1'b0);
        #1;
        cmp("reset_flag", 32'h0000_0001, 32'(rstf));
        step(1'b0, 1'b0);
        #1;
        cmp("reset_flag", 32'h0000_0000, 32'(rstf));
        $display("test reset done");
        complete_run();
    end

    // watchdog well past the expected run length
    initial begin
        #100000;
        errors++;
        complete_run();
    end
endmodule : ebsc_ctrl_tb
